// ===== spia_host.sv
// Controller end: AXI4-Lite command registers driving the serial link
module spia_host (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   spia_if.host             link,
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   localparam logic [4:0] HALF_M1 = 5'(spia_pkg::SCLK_HALF_CYC - 1);

   logic [31:0]             cmd_r;
   logic [31:0]             txd_r;
   logic [31:0]             rxd_r;
   logic [31:0]             wdata_r;
   logic [3:0]              wstrb_r;
   logic [4:0]              awaddr_r;
   logic                    aw_hold_r;
   logic                    w_hold_r;
   logic                    wr_go;
   logic                    busy;
   logic [1:0]              sync_q;
   logic                    rx_pin;
   logic [15:0]             instr;
   logic [47:0]             frame;
   logic [2:0]              nbytes;
   logic [5:0]              last_idx;
   logic [5:0]              pos;
   logic [4:0]              cnt_r;
   logic [5:0]              bit_r;
   logic                    cs_n_r;
   logic                    sclk_r;
   logic                    out_r;
   logic                    oe_n_r;
   spia_pkg::spia_host_st_t st_r;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic reg_ok(input logic [4:0] a);
      return a == spia_pkg::HREG_CMD || a == spia_pkg::HREG_TXD ||
             a == spia_pkg::HREG_RXD || a == spia_pkg::HREG_STAT;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Frame position of link bit i for the chosen order
   function automatic logic [5:0] fpos(input logic [5:0] i, input logic lsb_first);
      logic [5:0] j;
      j = i - 6'h10;
      if (i < 6'h10) begin
         return {2'h0, lsb_first ? i[3:0] : ~i[3:0]};
      end else begin
         return 6'h10 + {1'b0, j[4:3], lsb_first ? j[2:0] : ~j[2:0]};
      end
   endfunction

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   assign s_axi_awready = ce & ~aw_hold_r & ~s_axi_bvalid;
   assign s_axi_wready  = ce & ~w_hold_r & ~s_axi_bvalid;
   assign s_axi_arready = ce & ~s_axi_rvalid;
   assign wr_go         = ce & aw_hold_r & w_hold_r;
   assign busy          = st_r != spia_pkg::H_IDLE;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r    <= 1'b0;
         w_hold_r     <= 1'b0;
         awaddr_r     <= 5'h00;
         wdata_r      <= 32'h0000_0000;
         wstrb_r      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
         cmd_r        <= 32'h0000_0000;
         txd_r        <= 32'h0000_0000;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_r    <= 1'b0;
            w_hold_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= reg_ok(awaddr_r) ? 2'h0 : 2'h2;
            if (!busy && awaddr_r == spia_pkg::HREG_CMD) begin
               cmd_r <= merge(cmd_r, wdata_r, wstrb_r);
            end
            if (!busy && awaddr_r == spia_pkg::HREG_TXD) begin
               txd_r <= merge(txd_r, wdata_r, wstrb_r);
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'h0;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= reg_ok(s_axi_araddr) ? 2'h0 : 2'h2;
            unique case (s_axi_araddr)
               spia_pkg::HREG_CMD:  s_axi_rdata <= cmd_r;
               spia_pkg::HREG_TXD:  s_axi_rdata <= txd_r;
               spia_pkg::HREG_RXD:  s_axi_rdata <= rxd_r;
               spia_pkg::HREG_STAT: s_axi_rdata <= {31'h0000_0000, busy};
               default:             s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Serial engine
   // ------------------------------------------------------------
   spia_sync #(
      .W   (2),
      .RST (2'h0)
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .d       ({link.sdio, link.dedicated_serial_output_pin}),
      .q       (sync_q)
   );

   assign rx_pin   = cmd_r[spia_pkg::CMD_SEP] ? sync_q[0] : sync_q[1];
   assign instr    = {cmd_r[spia_pkg::CMD_RW], cmd_r[spia_pkg::CMD_LEN +: 2], 3'h0, cmd_r[9:0]};
   assign frame    = {txd_r, instr};
   assign nbytes   = (cmd_r[spia_pkg::CMD_LEN +: 2] == spia_pkg::LEN_STREAM) ?
                     {1'b0, cmd_r[spia_pkg::CMD_CNT +: 2]} + 3'h1 :
                     {1'b0, cmd_r[spia_pkg::CMD_LEN +: 2]} + 3'h1;
   assign last_idx = 6'h0F + {nbytes, 3'h0};
   assign pos      = fpos(bit_r, cmd_r[spia_pkg::CMD_LSB]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r   <= spia_pkg::H_IDLE;
         cnt_r  <= 5'h00;
         bit_r  <= 6'h00;
         cs_n_r <= 1'b1;
         sclk_r <= 1'b0;
         out_r  <= 1'b0;
         oe_n_r <= 1'b1;
         rxd_r  <= 32'h0000_0000;
      end else if (ce) begin
         cnt_r <= (st_r == spia_pkg::H_IDLE || cnt_r == HALF_M1) ? 5'h00 : cnt_r + 5'h01;
         unique case (st_r)
            spia_pkg::H_IDLE: begin
               if (wr_go && awaddr_r == spia_pkg::HREG_CMD) begin
                  st_r   <= spia_pkg::H_LOW;
                  bit_r  <= 6'h00;
                  cs_n_r <= 1'b0;
               end
            end
            spia_pkg::H_LOW: begin
               if (cnt_r == 5'h00) begin
                  out_r  <= frame[pos];
                  oe_n_r <= cmd_r[spia_pkg::CMD_RW] && bit_r >= 6'h10;
               end
               if (cnt_r == HALF_M1) begin
                  if (cmd_r[spia_pkg::CMD_RW] && bit_r >= 6'h10) begin
                     rxd_r[5'(pos - 6'h10)] <= rx_pin;
                  end
                  sclk_r <= 1'b1;
                  st_r   <= spia_pkg::H_HIGH;
               end
            end
            spia_pkg::H_HIGH: begin
               if (cnt_r == HALF_M1) begin
                  sclk_r <= 1'b0;
                  if (bit_r == last_idx) begin
                     oe_n_r <= 1'b1;
                     st_r   <= spia_pkg::H_END;
                  end else begin
                     bit_r <= bit_r + 6'h01;
                     st_r  <= spia_pkg::H_LOW;
                  end
               end
            end
            spia_pkg::H_END: begin
               if (cnt_r == HALF_M1) begin
                  cs_n_r <= 1'b1;
                  st_r   <= spia_pkg::H_IDLE;
               end
            end
         endcase
      end
   end

   assign link.cs_n           = cs_n_r;
   assign link.sclk           = sclk_r;
   assign link.host_sdio_o    = out_r;
   assign link.host_sdio_oe_n = oe_n_r;
endmodule

// ===== spia_pkg.sv
// Shared constants and types for the serial port instruction/address logic
package spia_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int SCLK_HALF_NS  = 80;
   localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // Device register map
   // ------------------------------------------------------------
   localparam logic [9:0] ADDR_CFG    = 10'h000;
   localparam logic [9:0] ADDR_PARTID = 10'h003;
   localparam logic [9:0] ADDR_RDBK   = 10'h004;
   localparam logic [9:0] ADDR_TOP    = 10'h232;
   localparam logic [7:0] CFG_RESET   = 8'h18;
   localparam logic [7:0] PART_ID     = 8'h5A; // Arbitrary value
   localparam logic [7:0] UPD_MASK    = 8'h01;
   localparam int         CFG_SEP_BIT = 0;
   localparam int         CFG_LSB_BIT = 1;
   localparam int         UPD_BIT     = 0;
   localparam int         RDBK_BIT    = 0;

   // ------------------------------------------------------------
   // Instruction word
   // ------------------------------------------------------------
   localparam int         RW_BIT     = 15;
   localparam int         LEN_MSB    = 14;
   localparam int         LEN_LSB    = 13;
   localparam logic [1:0] LEN_STREAM = 2'h3;

   // ------------------------------------------------------------
   // Controller registers (AXI4-Lite)
   // ------------------------------------------------------------
   localparam logic [4:0] HREG_CMD  = 5'h00;
   localparam logic [4:0] HREG_TXD  = 5'h04;
   localparam logic [4:0] HREG_RXD  = 5'h08;
   localparam logic [4:0] HREG_STAT = 5'h0C;
   localparam int         CMD_RW    = 31;
   localparam int         CMD_LEN   = 29;
   localparam int         CMD_CNT   = 26;
   localparam int         CMD_LSB   = 15;
   localparam int         CMD_SEP   = 14;

   typedef enum logic [1:0] {DEV_INSTR, DEV_DATA, DEV_DONE} spia_dev_st_t;
   typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_END} spia_host_st_t;
endpackage

// ===== spia_if.sv
// Serial link between controller and device, with pin resolution
interface spia_if;
   logic cs_n;
   logic sclk;
   logic host_sdio_o;
   logic host_sdio_oe_n;
   logic dev_sdio_o;
   logic dev_sdio_oe_n;
   logic dev_sdo_o;
   logic dev_sdo_oe_n;
   logic sdio;
   logic dedicated_serial_output_pin;

   // Undriven wires settle low
   assign sdio = !dev_sdio_oe_n ? dev_sdio_o : (!host_sdio_oe_n ? host_sdio_o : 1'b0);
   assign dedicated_serial_output_pin  = !dev_sdo_oe_n ? dev_sdo_o : 1'b0;

   modport dev (input cs_n, sclk, sdio, output dev_sdio_o, dev_sdio_oe_n, dev_sdo_o, dev_sdo_oe_n);
   modport host (output cs_n, sclk, host_sdio_o, host_sdio_oe_n, input sdio, dedicated_serial_output_pin);
endinterface

// ===== spia_sync.sv
// Two-flop synchroniser for pin inputs
module spia_sync #(
   parameter int           W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= RST;
         q      <= RST;
      end else if (ce) begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// ===== spia_dev.sv
// Device end: instruction decode, address sequencing, shadow/active registers
//
// Contract
// - Instruction MSB selects read or write
// - Next two bits give length or streaming
// - Low 13 bits give start address
// - Host keeps upper three address bits zero
// - Host sends exactly the coded byte count
// - Address steps once per further data byte
// - MSB-first order decrements the address
// - LSB-first order increments the address
// - Bit order applies to instruction and data
// - Reset state is MSB-first, decrementing
// - Host writes configuration byte mirrored
// - Configuration resets to long instruction value
// - Bit-order change takes effect immediately
// - Streaming ends at the top address
// - Sequencing visits every address, none skipped
// - Decrement wraps through zero to top
// - Sample on rising, launch on falling
// - Chip select mid-byte aborts and flushes
// - Writes go to shadow until update
// - Separate-output bit routes read data
module spia_dev (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       ce,
   spia_if.dev             link,
   input  wire logic [9:0] act_addr,
   output logic      [7:0] act_data,
   output logic            update_pulse,
   output logic      [7:0] cfg
);
   localparam int DEPTH = int'(spia_pkg::ADDR_TOP) + 1;

   logic [7:0]             shadow_mem [0:DEPTH-1];
   logic [7:0]             act_mem    [0:DEPTH-1];
   logic [2:0]             sync_q;
   logic                   cs_n_s;
   logic                   sclk_s;
   logic                   sdio_s;
   logic                   sclk_d_r;
   logic                   rise;
   logic                   fall;
   logic                   lsb;
   logic                   sep;
   logic                   drive;
   logic                   byte_wr;
   logic                   last;
   logic [15:0]            sh_r;
   logic [15:0]            sh_nxt;
   logic [3:0]             bit_r;
   logic                   rw_r;
   logic [1:0]             len_r;
   logic [1:0]             nb_r;
   logic [9:0]             addr_r;
   logic [9:0]             addr_nxt;
   logic [7:0]             tx_r;
   logic [7:0]             cfg_r;
   logic [7:0]             act_data_r;
   logic                   out_r;
   logic                   out_en_r;
   logic                   upd_r;
   spia_pkg::spia_dev_st_t st_r;

   // ------------------------------------------------------------
   // Pin synchronisation and clock edges
   // ------------------------------------------------------------
   spia_sync #(
      .W   (3),
      .RST (3'h4)
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .d       ({link.cs_n, link.sclk, link.sdio}),
      .q       (sync_q)
   );

   assign cs_n_s = sync_q[2];
   assign sclk_s = sync_q[1];
   assign sdio_s = sync_q[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sclk_d_r <= 1'b0;
      end else if (ce) begin
         sclk_d_r <= sclk_s;
      end
   end

   assign rise = sclk_s & ~sclk_d_r;
   assign fall = ~sclk_s & sclk_d_r;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] shift_in(input logic [15:0] s, input logic d,
                                            input logic lsb_first, input logic wide);
      if (!lsb_first) begin
         return {s[14:0], d};
      end else if (wide) begin
         return {d, s[15:1]};
      end else begin
         return {8'h00, d, s[7:1]};
      end
   endfunction

   function automatic logic [7:0] rd_byte(input logic [9:0] a);
      if (a == spia_pkg::ADDR_CFG) begin
         return cfg_r;
      end else if (a == spia_pkg::ADDR_PARTID) begin
         return spia_pkg::PART_ID;
      end else if (a > spia_pkg::ADDR_TOP) begin
         return 8'h00;
      end else if (act_mem[spia_pkg::ADDR_RDBK][spia_pkg::RDBK_BIT]) begin
         return act_mem[a];
      end else begin
         return shadow_mem[a];
      end
   endfunction

   assign lsb = cfg_r[spia_pkg::CFG_LSB_BIT];
   assign sep = cfg_r[spia_pkg::CFG_SEP_BIT];

   assign sh_nxt = shift_in(sh_r, sdio_s, lsb, st_r == spia_pkg::DEV_INSTR);

   always_comb begin
      if (lsb) begin
         addr_nxt = addr_r + 10'h001;
      end else if (addr_r == 10'h000) begin
         addr_nxt = spia_pkg::ADDR_TOP;
      end else begin
         addr_nxt = addr_r - 10'h001;
      end
   end

   assign last = (len_r == spia_pkg::LEN_STREAM) ? (addr_r == spia_pkg::ADDR_TOP) : (nb_r == len_r);

   assign byte_wr = ce & ~cs_n_s & rise & (st_r == spia_pkg::DEV_DATA) & (bit_r == 4'h7) & ~rw_r;

   // ------------------------------------------------------------
   // Transfer sequencer
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r   <= spia_pkg::DEV_INSTR;
         sh_r   <= 16'h0000;
         bit_r  <= 4'h0;
         rw_r   <= 1'b0;
         len_r  <= 2'h0;
         nb_r   <= 2'h0;
         addr_r <= 10'h000;
         tx_r   <= 8'h00;
         out_r  <= 1'b0;
         out_en_r <= 1'b0;
      end else if (ce) begin
         if (cs_n_s) begin
            out_en_r <= 1'b0;
            if (bit_r != 4'h0 || st_r == spia_pkg::DEV_DONE ||
                (st_r == spia_pkg::DEV_DATA && len_r == spia_pkg::LEN_STREAM)) begin
               st_r  <= spia_pkg::DEV_INSTR;
               bit_r <= 4'h0;
               sh_r  <= 16'h0000;
            end
         end else if (rise) begin
            unique case (st_r)
               spia_pkg::DEV_INSTR: begin
                  sh_r <= sh_nxt;
                  if (bit_r == 4'hF) begin
                     rw_r   <= sh_nxt[spia_pkg::RW_BIT];
                     len_r  <= sh_nxt[spia_pkg::LEN_MSB:spia_pkg::LEN_LSB];
                     addr_r <= sh_nxt[9:0];
                     tx_r   <= rd_byte(sh_nxt[9:0]);
                     nb_r   <= 2'h0;
                     bit_r  <= 4'h0;
                     st_r   <= spia_pkg::DEV_DATA;
                  end else begin
                     bit_r <= bit_r + 4'h1;
                  end
               end
               spia_pkg::DEV_DATA: begin
                  sh_r <= sh_nxt;
                  if (bit_r == 4'h7) begin
                     bit_r  <= 4'h0;
                     addr_r <= addr_nxt;
                     tx_r   <= rd_byte(addr_nxt);
                     nb_r   <= nb_r + 2'h1;
                     if (last) begin
                        st_r <= spia_pkg::DEV_DONE;
                     end
                  end else begin
                     bit_r <= bit_r + 4'h1;
                  end
               end
               spia_pkg::DEV_DONE: begin
               end
            endcase
         end else if (fall && st_r == spia_pkg::DEV_DATA && rw_r) begin
            out_en_r <= 1'b1;
            out_r <= lsb ? tx_r[0] : tx_r[7];
            tx_r  <= lsb ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
         end
      end
   end

   // ------------------------------------------------------------
   // Shadow and active registers
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            shadow_mem[i] <= 8'h00;
            act_mem[i]    <= 8'h00;
         end
      end else if (byte_wr && addr_r <= spia_pkg::ADDR_TOP) begin
         if (addr_r == spia_pkg::ADDR_TOP) begin
            if (sh_nxt[spia_pkg::UPD_BIT]) begin
               for (int i = 0; i < DEPTH - 1; i++) begin
                  act_mem[i] <= shadow_mem[i];
               end
               act_mem[spia_pkg::ADDR_TOP] <= sh_nxt[7:0] & ~spia_pkg::UPD_MASK;
            end
            shadow_mem[addr_r] <= sh_nxt[7:0] & ~spia_pkg::UPD_MASK;
         end else begin
            shadow_mem[addr_r] <= sh_nxt[7:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_r <= spia_pkg::CFG_RESET;
      end else if (byte_wr && addr_r == spia_pkg::ADDR_CFG) begin
         cfg_r <= sh_nxt[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         upd_r      <= 1'b0;
         act_data_r <= 8'h00;
      end else if (ce) begin
         upd_r      <= byte_wr & (addr_r == spia_pkg::ADDR_TOP) & sh_nxt[spia_pkg::UPD_BIT];
         act_data_r <= (act_addr <= spia_pkg::ADDR_TOP) ? act_mem[act_addr] : 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Pin drive
   // ------------------------------------------------------------
   // Drive only after the first launch, once the host has let go
   assign drive = ~cs_n_s & rw_r & (st_r == spia_pkg::DEV_DATA) & out_en_r;

   assign link.dev_sdio_o    = out_r;
   assign link.dev_sdo_o     = out_r;
   assign link.dev_sdio_oe_n = ~(drive & ~sep);
   assign link.dev_sdo_oe_n  = ~(drive & sep);

   assign act_data     = act_data_r;
   assign update_pulse = upd_r;
   assign cfg          = cfg_r;
endmodule

// ===== spia_assertions.sv
// Link checks between the controller and device ends
module spia_link_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic host_sdio_o,
   input wire logic host_sdio_oe_n,
   input wire logic dev_sdio_o,
   input wire logic dev_sdio_oe_n,
   input wire logic dev_sdo_o,
   input wire logic dev_sdo_oe_n
);
   default clocking dcb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sclk_gated_a: assert property ($changed(sclk) |-> !cs_n)
      else $error("sclk moved while deselected");
   sclk_high_a: assert property ($rose(sclk) |-> ##16 $fell(sclk))
      else $error("sclk high phase not 16 cycles");
   tx_hold_a: assert property (sclk && $past(sclk) |-> $stable(host_sdio_o))
      else $error("host data moved while sclk high");
   no_fight_a: assert property (host_sdio_oe_n || dev_sdio_oe_n)
      else $error("both ends drive sdio");
   one_pin_a: assert property (dev_sdio_oe_n || dev_sdo_oe_n)
      else $error("device drives both data pins");
   launch_fall_a: assert property (!cs_n && ($changed(dev_sdio_o) || $changed(dev_sdo_o)) |-> !sclk)
      else $error("read bit launched while sclk high");
   cs_setup_a: assert property ($fell(cs_n) |-> !sclk [*8])
      else $error("sclk rose too soon after select");
   cs_end_a: assert property ($rose(cs_n) |-> $past(sclk, 8) == 1'h0)
      else $error("deselect inside a clock phase");
   dev_quiet_a: assert property (!dev_sdio_oe_n |-> !$past(cs_n, 6))
      else $error("device drives while deselected");
   cover property ($fell(cs_n));
   cover property (!dev_sdio_oe_n);
   cover property (!dev_sdo_oe_n);
endmodule

// ===== test_serial_port_instruction_addressing.sv
// Bench joining controller and device ends with a register model
module test_serial_port_instruction_addressing;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic [4:0]  awa = 0, ara = 0, h;
   logic [31:0] wd = 0, rd, q, d;
   logic [9:0]  pa = 0;
   logic        awr, wrd, bv, arr, rv;
   logic [1:0]  br, rr;
   logic [7:0]  ad, cf;
   int          fails = 0, num_checks = 0, lsb = 0, sep = 0, a, i, sh[1024], ac[1024];
   spia_if lnk();
   always #2.5 aclk = ~aclk;
   spia_host i_spia_host (.aclk, .aresetn, .ce(1'h1), .link(lnk.host), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rry));
   spia_dev i_spia_dev (.aclk, .aresetn, .ce(1'h1), .link(lnk.dev), .act_addr(pa), .act_data(ad),
      .update_pulse(), .cfg(cf));
   spia_link_checker i_spia_link_checker (.aclk, .aresetn, .cs_n(lnk.cs_n), .sclk(lnk.sclk),
      .host_sdio_o(lnk.host_sdio_o), .host_sdio_oe_n(lnk.host_sdio_oe_n), .dev_sdio_o(lnk.dev_sdio_o),
      .dev_sdio_oe_n(lnk.dev_sdio_oe_n), .dev_sdo_o(lnk.dev_sdo_o), .dev_sdo_oe_n(lnk.dev_sdo_oe_n));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task tally_and_finish;
      $display("checks %0d errors %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (e !== s) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task bus(input logic w, input logic [4:0] adr, input logic [31:0] dat);
      int k;
      @(posedge aclk);
      awa <= adr;
      ara <= adr;
      wd <= dat;
      {awv, wv, bry, arv, rry} <= {w, w, w, !w, !w};
      h = 0;
      for (k = 0; k < 40 && !(h[2] || h[0]); k++) begin
         #1;
         h = {awv && awr, wv && wrd, bry && bv, arv && arr, rry && rv};
         if (h[0]) q = rd;
         if (h[2]) chk("bresp", 32'h0, {30'h0, br});
         if (h[0]) chk("rresp", 32'h0, {30'h0, rr});
         @(posedge aclk);
         {awv, wv, bry, arv, rry} <= {awv, wv, bry, arv, rry} & ~h;
      end
      if (k == 40) begin
         fails++;
         tally_and_finish();
      end
   endtask
   task xfer(input int rdn, len, n, sa, input logic [31:0] tx);
      int k, x;
      logic [31:0] e;
      bus(1, 5'h04, tx);
      bus(1, 5'h00, {rdn[0], len[1:0], 1'h0, 2'(n - 1), 10'h0, lsb[0], sep[0], 1'h0, sa[12:0]});
      x = sa;
      e = 0;
      for (k = 0; k < n; k++) begin
         if (rdn) e[8*k +: 8] = sh[x][7:0];
         else sh[x] = tx[8*k +: 8];
         if (!rdn && x == 10'h232 && tx[8*k]) ac = sh;
         if (x == 10'h232) break;
         x = lsb ? x + 1 : (x == 0 ? 10'h232 : x - 1);
      end
      for (k = 0; k < 1000; k++) begin
         bus(0, 5'h0C, 0);
         if (q[0] === 1'h0) break;
      end
      if (k == 1000) begin
         fails++;
         tally_and_finish();
      end
      if (rdn) bus(0, 5'h08, 0);
      if (rdn) chk("rxd", e, q & 32'h0000FFFF);
   endtask
   task peek(input int pa_i);
      pa <= pa_i[9:0];
      repeat (3) @(posedge aclk);
      #1;
      chk("act", ac[pa_i], {24'h0, ad});
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'h2cff));
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      repeat (4) @(posedge aclk);
      chk("cfg", 8'h18, cf);
      a = 32'h10 + $urandom_range(0, 32'h1F0);
      d = $urandom;
      xfer(0, 2, 3, a, d);
      peek(a);
      xfer(0, 0, 1, 32'h232, 32'h01);
      for (i = 0; i < 3; i++) peek(a - i);
      xfer(1, 1, 2, a, 0);
      xfer(0, 0, 1, 0, 32'h5A);
      chk("cfg", 8'h5A, cf);
      lsb = 1;
      xfer(0, 3, 4, 32'h230, {d[31:24], 8'h01, d[15:0]});
      peek(32'h230);
      peek(32'h231);
      xfer(0, 0, 1, 0, 32'hDB);
      sep = 1;
      xfer(1, 1, 2, 32'h230, 0);
      tally_and_finish();
   end
endmodule
